// *** inc/core_state_map.vh ***
`ifndef CORE_STATE_MAP_VH
`define CORE_STATE_MAP_VH

////////////////////////////////////////////////////////////////////////////
// register byte addresses on the apb
`define CSW_ADDR 8'h00
`define STACK_TOP_ADDR 8'h04
`define DPL_ADDR 8'h08
`define DPH_ADDR 8'h0C
`define ACC_VIEW_ADDR 8'h10
`define BANK_BASE_ADDR 8'h14

////////////////////////////////////////////////////////////////////////////
// core status word field positions
`define CSW_CARRY_BIT 7
`define CSW_AUX_BIT 6
`define CSW_USER0_BIT 5
`define CSW_BANK_HI_BIT 4
`define CSW_BANK_LO_BIT 3
`define CSW_WRAP_BIT 2
`define CSW_USER1_BIT 1
`define CSW_PARITY_BIT 0

////////////////////////////////////////////////////////////////////////////
// reset values
`define CSW_RESET 8'h00
`define STACK_TOP_RESET 8'h07
`define DATA_POINTER_RESET 16'h0000
`define PC_RESET 16'h0000

`endif

// *** design/bank_ram.v ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// working-register storage, four banks of eight bytes
module bank_ram #(
    parameter AW = 5,
    parameter DW = 8
) (
    input wire pclk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata_ff
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array; read data is registered
    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end

endmodule

// *** design/core_state_regs.v ***
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "core_state_map.vh"

// Behaviour
// - status word flag bits at fixed positions
// - two bank bits pick one of four banks
// - parity bit gives even parity with accumulator
// - stack top resets to 0x07
// - stack top increments before each push
// - data pointer is two addressable bytes
// - data pointer loads whole or by halves
// - data pointer addresses table reads, external moves
// - program counter sixteen bits, resets to zero
// - program counter advances on fetch and operand
// - program counter has no register address
module core_state_regs #(
    parameter PC_W = 16,
    parameter DP_W = 16
) (
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // execution unit side
    input wire [7:0] acc,
    input wire flags_we,
    input wire [7:0] flags_wdata,
    input wire push_req,
    input wire pop_req,
    input wire data_pointer_load16,
    input wire [DP_W-1:0] data_pointer_wdata,
    input wire data_pointer_inc,
    input wire fetch_step,
    input wire pc_load,
    input wire [PC_W-1:0] pc_wdata,
    input wire wreg_we,
    input wire [2:0] wreg_idx,
    input wire [7:0] wreg_wdata,
    output reg [7:0] core_status_word_ff,
    output reg [7:0] stack_top_ff,
    output reg [7:0] stack_addr_ff,
    output reg [DP_W-1:0] data_pointer_ff,
    output reg [DP_W-1:0] code_table_addr_ff,
    output reg [PC_W-1:0] program_counter_ff,
    output reg [4:0] bank_base_ff,
    output wire [7:0] wreg_rdata_ff
);

    ////////////////////////////////////////////////////////////////////////
    // apb phase tracker, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_ACC = 2'b10;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [31:0] nxt_prdata;
    reg nxt_pready;
    reg nxt_pslverr;

    // separate flag holders; parity is its own flop
    reg carry_flag_ff;
    reg aux_carry_flag_ff;
    reg user_flag_zero_ff;
    reg bank_select_high_ff;
    reg bank_select_low_ff;
    reg signed_wrap_flag_ff;
    reg user_flag_one_ff;
    reg parity_ff;

    reg [7:0] data_pointer_low_ff;
    reg [7:0] data_pointer_high_ff;
    reg [7:0] nxt_stack_top;
    reg [7:0] nxt_stack_addr;
    reg [7:0] nxt_dpl;
    reg [7:0] nxt_dph;
    reg [PC_W-1:0] nxt_pc;
    reg [7:0] nxt_flags;

    wire setup_ph;
    wire wr_take;
    wire [7:0] wbyte;
    wire [7:0] csw_now;
    wire [1:0] bank_sel;
    wire [4:0] wreg_addr;

    ////////////////////////////////////////////////////////////////////////
    // address decode helper, used by the read mux and the write path
    function hit;
        input [7:0] addr;
        input [7:0] offs;
        begin
            hit = (addr == offs);
        end
    endfunction

    function mapped;
        input [7:0] addr;
        begin
            mapped = hit(addr, `CSW_ADDR) | hit(addr, `STACK_TOP_ADDR) |
                     hit(addr, `DPL_ADDR) | hit(addr, `DPH_ADDR) |
                     hit(addr, `ACC_VIEW_ADDR) |
                     hit(addr, `BANK_BASE_ADDR);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus phases; a write lands only at the completing access edge
    assign setup_ph = psel & ~penable;
    assign wr_take = psel & penable & pready_ff & pwrite & mapped(paddr);
    assign wbyte = pwdata[7:0];

    assign csw_now = {carry_flag_ff, aux_carry_flag_ff, user_flag_zero_ff,
                      bank_select_high_ff, bank_select_low_ff,
                      signed_wrap_flag_ff, user_flag_one_ff, parity_ff};

    assign bank_sel = {bank_select_high_ff, bank_select_low_ff};
    assign wreg_addr = {bank_sel, wreg_idx};

    ////////////////////////////////////////////////////////////////////////
    // apb answer: data and ready are prepared during setup so that the
    // access phase completes with no wait state
    always @* begin
        nxt_state = state_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (setup_ph) begin
                    nxt_state = ST_ACC;
                    nxt_pready = 1'b1;
                    nxt_pslverr = ~mapped(paddr);
                    nxt_prdata = 32'h00000000;
                    if (!pwrite) begin
                        if (hit(paddr, `CSW_ADDR)) begin
                            nxt_prdata = {24'h000000, csw_now};
                        end else if (hit(paddr, `STACK_TOP_ADDR)) begin
                            nxt_prdata = {24'h000000, stack_top_ff};
                        end else if (hit(paddr, `DPL_ADDR)) begin
                            nxt_prdata = {24'h000000, data_pointer_low_ff};
                        end else if (hit(paddr, `DPH_ADDR)) begin
                            nxt_prdata = {24'h000000, data_pointer_high_ff};
                        end else if (hit(paddr, `ACC_VIEW_ADDR)) begin
                            nxt_prdata = {24'h000000, acc};
                        end else if (hit(paddr, `BANK_BASE_ADDR)) begin
                            nxt_prdata = {27'h0000000, bank_base_ff};
                        end
                    end
                end
            end
            ST_ACC: begin
                // transfer completes at this edge; drop ready
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // apb registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag writes; the bus write wins over an execution update in the
    // same cycle since both come from one instruction stream in practice
    always @* begin
        nxt_flags = csw_now;
        if (flags_we) begin
            nxt_flags = flags_wdata;
        end
        if (wr_take && hit(paddr, `CSW_ADDR)) begin
            nxt_flags = wbyte;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_flag_ff <= 1'b0;
            aux_carry_flag_ff <= 1'b0;
            user_flag_zero_ff <= 1'b0;
            bank_select_high_ff <= 1'b0;
            bank_select_low_ff <= 1'b0;
            signed_wrap_flag_ff <= 1'b0;
            user_flag_one_ff <= 1'b0;
        end else begin
            carry_flag_ff <= nxt_flags[`CSW_CARRY_BIT];
            aux_carry_flag_ff <= nxt_flags[`CSW_AUX_BIT];
            user_flag_zero_ff <= nxt_flags[`CSW_USER0_BIT];
            bank_select_high_ff <= nxt_flags[`CSW_BANK_HI_BIT];
            bank_select_low_ff <= nxt_flags[`CSW_BANK_LO_BIT];
            signed_wrap_flag_ff <= nxt_flags[`CSW_WRAP_BIT];
            user_flag_one_ff <= nxt_flags[`CSW_USER1_BIT];
        end
    end

    // parity follows the accumulator one edge later; written values for
    // this bit are dropped
    // even parity tracking
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_ff <= 1'b0;
        end else begin
            parity_ff <= ^acc;
        end
    end

    // status word copy and bank base for the register file
    // bank base is code times eight
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_status_word_ff <= `CSW_RESET;
            bank_base_ff <= 5'h00;
        end else begin
            core_status_word_ff <= {nxt_flags[7:1], ^acc};
            bank_base_ff <= {nxt_flags[`CSW_BANK_HI_BIT],
                             nxt_flags[`CSW_BANK_LO_BIT], 3'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stack top: push pre-increments and points the write at the new top,
    // pop reads the current top then steps down; wraps modulo 256
    always @* begin
        nxt_stack_top = stack_top_ff;
        nxt_stack_addr = stack_addr_ff;
        if (push_req) begin
            nxt_stack_top = stack_top_ff + 8'h01;
            nxt_stack_addr = stack_top_ff + 8'h01;
        end else if (pop_req) begin
            nxt_stack_top = stack_top_ff - 8'h01;
            nxt_stack_addr = stack_top_ff;
        end
        if (wr_take && hit(paddr, `STACK_TOP_ADDR)) begin
            nxt_stack_top = wbyte;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_top_ff <= `STACK_TOP_RESET;
            stack_addr_ff <= `STACK_TOP_RESET;
        end else begin
            stack_top_ff <= nxt_stack_top;
            stack_addr_ff <= nxt_stack_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data pointer halves; a whole load beats increment, byte writes from
    // the bus beat both so software sees its own write
    always @* begin
        nxt_dpl = data_pointer_low_ff;
        nxt_dph = data_pointer_high_ff;
        if (data_pointer_load16) begin
            nxt_dpl = data_pointer_wdata[7:0];
            nxt_dph = data_pointer_wdata[15:8];
        end else if (data_pointer_inc) begin
            {nxt_dph, nxt_dpl} = data_pointer_ff + 16'h0001;
        end
        if (wr_take && hit(paddr, `DPL_ADDR)) begin
            nxt_dpl = wbyte;
        end
        if (wr_take && hit(paddr, `DPH_ADDR)) begin
            nxt_dph = wbyte;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_pointer_low_ff <= 8'h00;
            data_pointer_high_ff <= 8'h00;
            data_pointer_ff <= `DATA_POINTER_RESET;
        end else begin
            data_pointer_low_ff <= nxt_dpl;
            data_pointer_high_ff <= nxt_dph;
            data_pointer_ff <= {nxt_dph, nxt_dpl};
        end
    end

    // table read address is pointer plus accumulator, wrapping at 64k;
    // external moves use data_pointer_ff directly
    // indexed code address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_table_addr_ff <= `DATA_POINTER_RESET;
        end else begin
            code_table_addr_ff <= {nxt_dph, nxt_dpl} + {8'h00, acc};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter: load for jumps, else step once per fetched byte
    always @* begin
        nxt_pc = program_counter_ff;
        if (pc_load) begin
            nxt_pc = pc_wdata;
        end else if (fetch_step) begin
            nxt_pc = program_counter_ff + 16'h0001;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_ff <= `PC_RESET;
        end else begin
            program_counter_ff <= nxt_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // working registers live in the bank addressed by the select bits
    // bank-relative addressing
    bank_ram #(
        .AW(5),
        .DW(8)
    ) u_bank_ram (
        .pclk(pclk),
        .we(wreg_we),
        .waddr(wreg_addr),
        .wdata(wreg_wdata),
        .raddr(wreg_addr),
        .rdata_ff(wreg_rdata_ff)
    );

endmodule

// *** verif/core_state_asserts.sv ***
`timescale 1ns/1ps
module core_state_asserts #(
    parameter PC_W = 16,
    parameter DP_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata_ff,
    input wire pready_ff,
    input wire pslverr_ff,
    input wire [7:0] acc,
    input wire push_req,
    input wire data_pointer_load16,
    input wire [DP_W-1:0] data_pointer_wdata,
    input wire fetch_step,
    input wire pc_load,
    input wire [7:0] core_status_word_ff,
    input wire [7:0] stack_top_ff,
    input wire [7:0] stack_addr_ff,
    input wire [DP_W-1:0] data_pointer_ff,
    input wire [PC_W-1:0] program_counter_ff,
    input wire [4:0] bank_base_ff
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// an apb write to the same register wins over execution updates, so exclude any apb write
wire apb_wr = psel && penable && pwrite;
wire [6:0] csw_w = pwdata[7:1];
sequence setup_s;
    psel && !penable;
endsequence
sequence bank_quiet_s;
    $stable(core_status_word_ff[4:3]) [*2];
endsequence
a_parity_even: assert property (
    $past(presetn) |-> core_status_word_ff[0] == ^$past(acc))
    else $error("parity bit wrong");
a_reset_vals: assert property (
    $rose(presetn) |-> stack_top_ff == 8'h07 &&
    program_counter_ff == 0 && data_pointer_ff == 0)
    else $error("reset value wrong");
a_push_pre_inc: assert property (
    push_req && !apb_wr |=> stack_top_ff == $past(stack_top_ff) + 8'h01
    && stack_addr_ff == stack_top_ff)
    else $error("push did not pre-increment");
a_pc_fetch: assert property (
    fetch_step && !pc_load |=>
    program_counter_ff == $past(program_counter_ff) + 1'b1)
    else $error("pc did not advance");
a_data_pointer_whole: assert property (
    data_pointer_load16 && !apb_wr |=> data_pointer_ff == $past(data_pointer_wdata))
    else $error("pointer load lost");
a_ready_pulse: assert property (
    setup_s |=> pready_ff ##1 !pready_ff)
    else $error("ready not a one-cycle pulse");
a_pc_unmapped: assert property (
    (setup_s and paddr > 8'h14) |=> pslverr_ff && prdata_ff == 32'h0)
    else $error("unmapped access not refused");
a_csw_write: assert property (
    apb_wr && pready_ff && paddr == 8'h00 |=>
    core_status_word_ff[7:1] == $past(csw_w))
    else $error("status write lost");
a_bank_base: assert property (
    bank_quiet_s |-> bank_base_ff == {core_status_word_ff[4:3], 3'b000})
    else $error("bank base wrong");
endmodule
bind core_state_regs core_state_asserts #(.PC_W(PC_W), .DP_W(DP_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .acc(acc), .push_req(push_req), .data_pointer_load16(data_pointer_load16),
    .data_pointer_wdata(data_pointer_wdata), .fetch_step(fetch_step), .pc_load(pc_load),
    .core_status_word_ff(core_status_word_ff), .stack_top_ff(stack_top_ff),
    .stack_addr_ff(stack_addr_ff), .data_pointer_ff(data_pointer_ff),
    .program_counter_ff(program_counter_ff), .bank_base_ff(bank_base_ff));

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
reg pclk, presetn, psel, penable, pwrite, err;
reg [7:0] paddr, acc, flags_wdata, wreg_wdata;
reg [31:0] pwdata, seed, rd;
reg push_req, pop_req, data_pointer_load16, data_pointer_inc, fetch_step, pc_load;
reg flags_we, wreg_we;
reg [2:0] wreg_idx;
reg [15:0] data_pointer_wdata, pc_wdata, e16;
wire [31:0] prdata_ff;
wire pready_ff, pslverr_ff;
wire [7:0] core_status_word_ff, stack_top_ff, stack_addr_ff, wreg_rdata_ff;
wire [15:0] data_pointer_ff, code_table_addr_ff, program_counter_ff;
wire [4:0] bank_base_ff;
integer n_errors, num_checks, i, k;
core_state_regs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .acc(acc), .flags_we(flags_we), .flags_wdata(flags_wdata),
    .push_req(push_req), .pop_req(pop_req), .data_pointer_load16(data_pointer_load16),
    .data_pointer_wdata(data_pointer_wdata), .data_pointer_inc(data_pointer_inc), .fetch_step(fetch_step),
    .pc_load(pc_load), .pc_wdata(pc_wdata), .wreg_we(wreg_we),
    .wreg_idx(wreg_idx), .wreg_wdata(wreg_wdata),
    .core_status_word_ff(core_status_word_ff), .stack_top_ff(stack_top_ff),
    .stack_addr_ff(stack_addr_ff), .data_pointer_ff(data_pointer_ff),
    .code_table_addr_ff(code_table_addr_ff),
    .program_counter_ff(program_counter_ff), .bank_base_ff(bank_base_ff),
    .wreg_rdata_ff(wreg_rdata_ff));
// 40 MHz core clock
initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
end
function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task tick(input integer n);
    repeat (n) @(posedge pclk);
endtask
task end_of_test;
    begin
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
endtask
task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    end
endtask
// one apb transfer; read data and error taken at the ready edge only
task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready_ff !== 1'b1 && n < 20);
        if (pready_ff !== 1'b1) begin
            n_errors = n_errors + 1;
            end_of_test;
        end
        rd = prdata_ff;
        err = pslverr_ff;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
initial begin
    {psel, penable, pwrite, paddr, pwdata, acc, flags_we} = 0;
    {push_req, pop_req, data_pointer_load16, data_pointer_inc, fetch_step, pc_load} = 0;
    {flags_wdata, wreg_we, wreg_idx, wreg_wdata, data_pointer_wdata, pc_wdata} = 0;
    presetn = 1'b0;
    seed = 32'h2003;
    n_errors = 0;
    num_checks = 0;
    tick(5);
    presetn <= 1'b1;
    // stack after reset, first push lands one above
    for (k = 0; k < 2; k = k + 1) begin
        tick(1);
        chk("pc", 0, program_counter_ff);
        chk("dp", 0, data_pointer_ff);
        apb(8'h04, 1'b0, 0);
        chk("stack", 8'h07, rd);
        push_req <= 1'b1;
        tick(1);
        push_req <= 1'b0;
        tick(1);
        chk("push top", 8'h08, stack_top_ff);
        chk("push addr", 8'h08, stack_addr_ff);
        pop_req <= 1'b1;
        tick(1);
        pop_req <= 1'b0;
        tick(1);
        chk("pop top", 8'h07, stack_top_ff);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
    end
    $display("test stack done");
    // random status writes; bit0 must follow the accumulator
    for (k = 0; k < 8; k = k + 1) begin
        seed = lfsr(seed);
        acc <= seed[7:0];
        apb(8'h00, 1'b1, {24'h0, seed[15:8]});
        apb(8'h00, 1'b0, 0);
        chk("csw", {seed[15:9], ^seed[7:0]}, rd);
        flags_we <= 1'b1;
        flags_wdata <= seed[31:24];
        tick(1);
        flags_we <= 1'b0;
        tick(1);
        chk("flags", {seed[31:25], ^acc}, core_status_word_ff);
    end
    $display("test status done");
    // every bank code, same index, distinct data
    wreg_idx <= 3'd3;
    for (i = 0; i < 8; i = i + 1) begin
        k = (i < 4) ? i : 7 - i;
        apb(8'h00, 1'b1, k << 3);
        tick(2);
        chk("bank", k * 8, bank_base_ff);
        if (i < 4) begin
            wreg_wdata <= 8'hA0 + k;
            wreg_we <= 1'b1;
            tick(1);
            wreg_we <= 1'b0;
        end else
            chk("wreg", 8'hA0 + k, wreg_rdata_ff);
    end
    $display("test bank done");
    // pointer whole load, byte halves, increment, table address
    seed = lfsr(seed);
    data_pointer_wdata <= seed[15:0];
    data_pointer_load16 <= 1'b1;
    tick(1);
    data_pointer_load16 <= 1'b0;
    apb(8'h08, 1'b0, 0);
    chk("dpl", seed[7:0], rd);
    apb(8'h0C, 1'b0, 0);
    chk("dph", seed[15:8], rd);
    apb(8'h08, 1'b1, seed[23:16]);
    apb(8'h0C, 1'b1, seed[31:24]);
    data_pointer_inc <= 1'b1;
    tick(1);
    data_pointer_inc <= 1'b0;
    tick(2);
    e16 = seed[31:16] + 16'h0001;
    chk("dp", e16, data_pointer_ff);
    // table address wraps at 64k, so the sum is cut to 16 bits first
    e16 = e16 + {8'h00, acc};
    chk("table", e16, code_table_addr_ff);
    // accumulator view feeds the same parity source
    apb(8'h10, 1'b0, 0);
    chk("acc view", acc, rd);
    $display("test pointer done");
    // jump then fetch, including wrap past the top
    for (k = 0; k < 2; k = k + 1) begin
        seed = lfsr(seed);
        e16 = k ? 16'hFFFE : seed[15:0];
        pc_wdata <= e16;
        pc_load <= 1'b1;
        tick(1);
        pc_load <= 1'b0;
        fetch_step <= 1'b1;
        tick(3);
        fetch_step <= 1'b0;
        apb(8'h18, 1'b1, 32'h0000FFFF);
        chk("pc err", 1, err);
        // counter wraps past the top, keep the expectation 16 bits wide
        e16 = e16 + 16'h0003;
        chk("pc", e16, program_counter_ff);
    end
    $display("test pc done");
    end_of_test;
end
endmodule
